// ===== rtl/ppr_fifo2.sv
`timescale 1ns/100ps
`default_nettype none
module ppr_fifo2 #(
   parameter int W = 8
) (
   // clock, reset, enable
   input  wire logic         clk_i,
   input  wire logic         resetn_i,
   input  wire logic         ce_i,
   // filling side
   input  wire logic         in_valid_i,
   input  wire logic [W-1:0] in_data_i,
   output logic              in_ready_o,
   // draining side, straight from flops
   output logic              out_valid_o,
   output logic [W-1:0]      out_data_o,
   input  wire logic         out_ready_i
);
   logic [W-1:0] d1_ff;
   logic         v1_ff;
   wire          pop_w  = out_valid_o & out_ready_i;
   wire          push_w = in_valid_i & ~v1_ff;

   // full only when the second slot holds a word
   assign in_ready_o = ~v1_ff;

   // head slot feeds the output, second slot takes overflow
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         out_valid_o <= 1'b0;
         out_data_o  <= '0;
         v1_ff       <= 1'b0;
         d1_ff       <= '0;
      end else if (ce_i) begin
         if (pop_w && v1_ff) begin
            out_data_o <= d1_ff;
            v1_ff      <= 1'b0;
         end else if (push_w && (pop_w || !out_valid_o)) begin
            out_data_o  <= in_data_i;
            out_valid_o <= 1'b1;
         end else if (push_w) begin
            d1_ff <= in_data_i;
            v1_ff <= 1'b1;
         end else if (pop_w) begin
            out_valid_o <= 1'b0;
         end
      end
   end
endmodule // ppr_fifo2
`default_nettype wire

// ===== rtl/ppr_pkg.sv
package ppr_pkg;

   // command codes decoded from the command byte
   localparam logic [7:0] CMD_T1_POLL  = 8'h3f;
   localparam logic [7:0] CMD_POLL     = 8'h40;
   localparam logic [7:0] CMD_DOWNLOAD = 8'h26;

   // parameter-byte pairs that qualify the poll command
   localparam logic [7:0] POLL_MAIN    = 8'h00;
   localparam logic [7:0] POLL_RESET   = 8'h4f;
   localparam logic [7:0] POLL_NULL    = 8'h4e;

   // acknowledge and result bytes
   localparam logic [7:0] BYTE_ACK     = 8'h41;
   localparam logic [7:0] BYTE_NAK     = 8'h4e;
   localparam logic [7:0] BYTE_DONE    = 8'h43;
   localparam logic [7:0] BYTE_ERR     = 8'h45;

   // payload lengths in bytes
   localparam logic [7:0] T1_LEN       = 8'h0c;
   localparam logic [7:0] POLL_LEN     = 8'h04;
   localparam logic [7:0] BLOCK_LEN    = 8'h80;
   localparam logic [16:0] BLOCK_RND   = 17'h0007f;

   // answer slots: one per host attempt
   localparam logic [4:0] SLOT_FIRST   = 5'h01;
   localparam logic [4:0] SLOT_LAST    = 5'h1c;

   // handler stream end record and self-start codes
   localparam logic [7:0] REC_END      = 8'h0b;
   localparam logic [7:0] START_NONE   = 8'h00;
   localparam logic [7:0] START_ABS    = 8'h01;
   localparam logic [7:0] START_REL    = 8'h02;

   // one command frame as handed over by the frame receiver
   typedef struct packed {
      logic [7:0] dev_id;
      logic [7:0] cmd;
      logic [7:0] first_parameter_byte;
      logic [7:0] second_parameter_byte;
      logic [7:0] csum;
   } ppr_frame_s;

   // static configuration, captured while reset is held
   typedef struct packed {
      logic [7:0]  dev_addr;
      logic [7:0]  version;
      logic [15:0] hsize;
      logic [4:0]  slot;
      logic [7:0]  letter;
      logic [7:0]  unit;
   } ppr_cfg_s;

   typedef enum logic [2:0] {ST_IDLE, ST_ACK, ST_RES, ST_DATA, ST_SUM} ppr_state_e;
   typedef enum logic [1:0] {SRC_T1, SRC_POLL, SRC_IMG} ppr_src_e;

   // end-around-carry byte sum
   function automatic logic [7:0] ppr_eac(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[7:0] + {7'h00, s[8]};
   endfunction

endpackage

// ===== rtl/ppr_responder.sv
// What this block does
// - type-one poll: skip parameters, send twelve bytes
// - type-one poll answered once per power-up
// - poll recognised by command code, address ignored
// - code 0x40 is a poll under any address
// - poll reset clears poll state, sends nothing
// - main poll counts retries, answers in own slot
// - answer slot lies within the 28 attempts
// - poll answer: size lo, size hi, address, version
// - reported handler size is always even
// - answered poll suppresses further answers until reset
// - null poll only clears the retry counter
// - targeted poll matches device letter and unit
// - download returns 128-byte block named by parameter
// - block beyond reported size gets a negative acknowledge
// - handler stream made of typed, length-prefixed records
// - stream ends with end record and start address
// - frame accepted only when end-around sum matches
// - acknowledge 0x41 valid, 0x4e invalid command
// - result 0x43 success, 0x45 failure, before data
`timescale 1ns/100ps
`default_nettype none
module ppr_responder #(
   parameter int IMG_DEPTH = 2048,
   parameter int AW        = 11
) (
   // clock, reset, enable
   input  wire logic                clk_i,
   input  wire logic                resetn_i,
   input  wire logic                ce_i,
   // decoded command frames
   input  wire ppr_pkg::ppr_frame_s frame_i,
   input  wire logic                frame_valid_i,
   // configuration, captured during reset
   input  wire ppr_pkg::ppr_cfg_s   cfg_i,
   input  wire logic [95:0]         t1_desc_i,
   // handler image load port
   input  wire logic                img_we_i,
   input  wire logic [AW-1:0]       img_addr_i,
   input  wire logic [7:0]          img_data_i,
   // reply bytes to the transmitter
   output logic                     tx_valid_o,
   output logic [7:0]               tx_data_o,
   input  wire logic                tx_ready_i,
   // status
   output logic                     busy_o,
   output logic                     poll_done_o,
   output logic                     t1_done_o
);
   import ppr_pkg::*;

   ppr_cfg_s    cfg_ff;
   logic [95:0] desc_ff;
   ppr_state_e  state_ff;
   ppr_state_e  nxt_state;
   ppr_src_e    src_ff;
   ppr_src_e    nxt_src;
   logic [4:0]  poll_cnt_ff;
   logic [4:0]  nxt_poll_cnt;
   logic        poll_done_ff;
   logic        nxt_poll_done;
   logic        t1_done_ff;
   logic        nak_ff;
   logic        err_ff;
   logic [7:0]  len_ff;
   logic [7:0]  nxt_len;
   logic [7:0]  idx_ff;
   logic [7:0]  blk_ff;
   logic [7:0]  sum_ff;
   logic [7:0]  img_mem [IMG_DEPTH];

   // configuration held still from reset release onward
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         cfg_ff  <= cfg_i;
         desc_ff <= t1_desc_i;
      end
   end

   // handler image as loaded, served byte for byte
   always_ff @(posedge clk_i) begin
      if (ce_i && img_we_i) begin
         img_mem[img_addr_i] <= img_data_i;
      end
   end

   // slot pulled into the host's range of attempts
   wire [4:0] slot_w = (cfg_ff.slot < SLOT_FIRST) ? SLOT_FIRST :
                       (cfg_ff.slot > SLOT_LAST)  ? SLOT_LAST  : cfg_ff.slot;

   // odd size rounded up, 0xffff down to 0xfffe, so the host never reads half a word
   wire [16:0] size_up_w  = {1'b0, cfg_ff.hsize} + {16'h0000, cfg_ff.hsize[0]};
   wire [15:0] rpt_size_w = size_up_w[16] ? 16'hfffe : {size_up_w[15:1], 1'b0};
   wire [16:0] blk_sum_w  = {1'b0, rpt_size_w} + BLOCK_RND;
   wire [9:0]  nblk_w     = blk_sum_w[16:7];

   // frame check and command decode
   wire [7:0] p1_w     = frame_i.first_parameter_byte;
   wire [7:0] p2_w     = frame_i.second_parameter_byte;
   wire [7:0] sum4_w   = ppr_eac(ppr_eac(ppr_eac(frame_i.dev_id, frame_i.cmd), p1_w), p2_w);
   wire       sum_ok_w = (sum4_w == frame_i.csum);
   wire       idle_w   = (state_ff == ST_IDLE);
   wire       accept_w = ce_i & frame_valid_i & idle_w & sum_ok_w;
   wire       mine_w   = (frame_i.dev_id == cfg_ff.dev_addr);
   wire       poll_w   = (frame_i.cmd == CMD_POLL);
   wire       main_w   = poll_w & (p1_w == POLL_MAIN) & (p2_w == POLL_MAIN);
   wire       rstp_w   = poll_w & (p1_w == POLL_RESET) & (p2_w == POLL_RESET);
   wire       nullp_w  = poll_w & (p1_w == POLL_NULL) & (p2_w == POLL_NULL);
   wire       t4_w     = poll_w & (p1_w == cfg_ff.letter) & (p2_w == cfg_ff.unit);
   wire       t1_w     = mine_w & (frame_i.cmd == CMD_T1_POLL);
   wire       dl_w     = mine_w & (frame_i.cmd == CMD_DOWNLOAD);
   // no disk address is decoded, so no boot sector reply can race a drive
   wire       other_w  = mine_w & ~poll_w & ~t1_w & ~dl_w;

   // retry counter saturates instead of wrapping into slot one again
   wire [4:0] cnt_inc_w = (poll_cnt_ff == 5'h1f) ? poll_cnt_ff : poll_cnt_ff + 5'h01;
   wire       hit_main_w = main_w & ~poll_done_ff & (cnt_inc_w == slot_w);
   wire       hit_t4_w   = t4_w & ~main_w & ~poll_done_ff;
   wire       dl_bad_w   = ({2'b00, p1_w} >= nblk_w);
   wire [14:0] dl_top_w  = {p1_w, 7'h7f};
   wire       dl_err_w   = (dl_top_w >= 15'(IMG_DEPTH));

   wire       nak_w   = (t1_w & t1_done_ff) | (dl_w & dl_bad_w) | other_w;
   wire       reply_w = hit_main_w | hit_t4_w | t1_w | dl_w | other_w;

   // retry counter and poll flag updates
   always_comb begin
      nxt_poll_cnt  = poll_cnt_ff;
      nxt_poll_done = poll_done_ff;
      if (accept_w) begin
         if (rstp_w) begin
            nxt_poll_cnt  = 5'h00;
            nxt_poll_done = 1'b0;
         end else if (nullp_w) begin
            nxt_poll_cnt = 5'h00;
         end else if (main_w) begin
            nxt_poll_cnt  = cnt_inc_w;
            nxt_poll_done = poll_done_ff | hit_main_w;
         end else begin
            nxt_poll_cnt = 5'h00;
            nxt_poll_done = poll_done_ff | hit_t4_w;
         end
      end
   end

   // payload source and length chosen at decode
   always_comb begin
      nxt_src = SRC_IMG;
      nxt_len = BLOCK_LEN;
      if (t1_w) begin
         nxt_src = SRC_T1;
         nxt_len = T1_LEN;
      end else if (poll_w) begin
         nxt_src = SRC_POLL;
         nxt_len = POLL_LEN;
      end
   end

   // reply byte selection
   wire [95:0] desc_sh_w = desc_ff >> {idx_ff[3:0], 3'b000};
   wire [7:0]  poll_byte_w = (idx_ff[1:0] == 2'h0) ? rpt_size_w[7:0]  :
                             (idx_ff[1:0] == 2'h1) ? rpt_size_w[15:8] :
                             (idx_ff[1:0] == 2'h2) ? cfg_ff.dev_addr  : cfg_ff.version;
   // records and end record pass through untouched, in stored order
   wire [14:0] img_idx_w  = {blk_ff, idx_ff[6:0]};
   wire        img_in_w   = (img_idx_w < 15'(IMG_DEPTH));
   wire [7:0]  img_byte_w = img_in_w ? img_mem[img_idx_w[AW-1:0]] : 8'h00;
   wire [7:0]  data_w     = (src_ff == SRC_T1)   ? desc_sh_w[7:0] :
                            (src_ff == SRC_POLL) ? poll_byte_w    : img_byte_w;
   wire [7:0]  ackb_w     = nak_ff ? BYTE_NAK : BYTE_ACK;
   wire [7:0]  resb_w     = err_ff ? BYTE_ERR : BYTE_DONE;
   wire [7:0]  byte_w     = (state_ff == ST_ACK) ? ackb_w :
                            (state_ff == ST_RES) ? resb_w :
                            (state_ff == ST_SUM) ? sum_ff : data_w;

   // a byte leaves only while the buffer has room
   logic buf_ready;
   wire  push_w   = ce_i & ~idle_w & buf_ready;
   wire  last_w   = (idx_ff == len_ff - 8'h01);

   // sequence: acknowledge, result, data, checksum
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (accept_w && reply_w) begin
               nxt_state = ST_ACK;
            end
         end
         ST_ACK: begin
            if (push_w) begin
               nxt_state = nak_ff ? ST_IDLE : ST_RES;
            end
         end
         ST_RES: begin
            if (push_w) begin
               nxt_state = ST_DATA;
            end
         end
         ST_DATA: begin
            if (push_w && last_w) begin
               nxt_state = ST_SUM;
            end
         end
         ST_SUM: begin
            if (push_w) begin
               nxt_state = ST_IDLE;
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   // state and poll flags
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         state_ff     <= ST_IDLE;
         poll_cnt_ff  <= 5'h00;
         poll_done_ff <= 1'b0;
      end else if (ce_i) begin
         state_ff     <= nxt_state;
         poll_cnt_ff  <= nxt_poll_cnt;
         poll_done_ff <= nxt_poll_done;
      end
   end

   // only a power-up reset clears the type-one flag
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         t1_done_ff <= 1'b0;
      end else if (accept_w && t1_w) begin
         t1_done_ff <= 1'b1;
      end
   end

   // reply descriptor latched at decode
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         nak_ff <= 1'b0;
         err_ff <= 1'b0;
         src_ff <= SRC_IMG;
         len_ff <= BLOCK_LEN;
         blk_ff <= 8'h00;
      end else if (accept_w && reply_w) begin
         nak_ff <= nak_w;
         err_ff <= dl_w & dl_err_w;
         src_ff <= nxt_src;
         len_ff <= nxt_len;
         blk_ff <= p1_w;
      end
   end

   // byte index and running data checksum
   always_ff @(posedge clk_i) begin
      if (!resetn_i || (ce_i && idle_w)) begin
         idx_ff <= 8'h00;
         sum_ff <= 8'h00;
      end else if (push_w && state_ff == ST_DATA) begin
         idx_ff <= idx_ff + 8'h01;
         sum_ff <= ppr_eac(sum_ff, data_w);
      end
   end

   // status outputs
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         busy_o      <= 1'b0;
         poll_done_o <= 1'b0;
         t1_done_o   <= 1'b0;
      end else if (ce_i) begin
         busy_o      <= (nxt_state != ST_IDLE);
         poll_done_o <= nxt_poll_done;
         t1_done_o   <= t1_done_ff | (accept_w & t1_w);
      end
   end

   // two-entry buffer: a transmitter stall stops the sequencer, not the data
   ppr_fifo2 #(.W(8)) u_buf (
      .clk_i       (clk_i),
      .resetn_i    (resetn_i),
      .ce_i        (ce_i),
      .in_valid_i  (~idle_w),
      .in_data_i   (byte_w),
      .in_ready_o  (buf_ready),
      .out_valid_o (tx_valid_o),
      .out_data_o  (tx_data_o),
      .out_ready_i (tx_ready_i)
   );

   // checks on the decode and the reply sequence
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   bad_sum_drop_a: assert property (
      ce_i && frame_valid_i && idle_w && !sum_ok_w
      |=> state_ff == ST_IDLE && $stable(poll_cnt_ff))
      else $error("frame with bad checksum was acted on");

   poll_reset_quiet_a: assert property (
      accept_w && rstp_w
      |=> state_ff == ST_IDLE && poll_cnt_ff == 5'h00 && !poll_done_ff)
      else $error("poll reset replied or left poll state");

   null_poll_a: assert property (
      accept_w && nullp_w ##1 1'b1
      |-> state_ff == ST_IDLE && poll_cnt_ff == 5'h00 && $stable(poll_done_ff))
      else $error("null poll did more than clear the counter");

   slot_answer_a: assert property (
      accept_w && main_w && !poll_done_ff && cnt_inc_w == slot_w
      |=> state_ff == ST_ACK && !nak_ff && src_ff == SRC_POLL)
      else $error("main poll not answered in own slot");

   poll_once_a: assert property (
      accept_w && main_w && poll_done_ff |=> state_ff == ST_IDLE)
      else $error("main poll answered twice");

   t1_decline_a: assert property (
      accept_w && t1_w && t1_done_ff |=> state_ff == ST_ACK && nak_ff)
      else $error("repeated type-one poll not declined");

   ack_byte_a: assert property (
      push_w && state_ff == ST_ACK
      |-> (byte_w == BYTE_ACK || byte_w == BYTE_NAK) && (src_ff != SRC_POLL || byte_w == BYTE_ACK))
      else $error("bad acknowledge byte");

   result_byte_a: assert property (
      push_w && state_ff == ST_RES && src_ff != SRC_IMG
      |-> byte_w == BYTE_DONE ##1 state_ff == ST_DATA)
      else $error("poll result not complete before data");

   size_even_a: assert property (rpt_size_w[0] == 1'b0)
      else $error("reported handler size is odd");

   block_len_a: assert property (
      state_ff == ST_DATA && src_ff == SRC_IMG |-> len_ff == BLOCK_LEN)
      else $error("download block is not 128 bytes");

   slot_range_a: assert property (
      slot_w >= SLOT_FIRST && slot_w <= SLOT_LAST)
      else $error("answer slot outside host attempts");

   poll_served_c: cover property (state_ff == ST_SUM && src_ff == SRC_POLL && push_w);
   t1_served_c:   cover property (state_ff == ST_SUM && src_ff == SRC_T1 && push_w);
   block_done_c:  cover property (state_ff == ST_SUM && src_ff == SRC_IMG && push_w);
   stall_c:       cover property (!idle_w && !buf_ready);

endmodule // ppr_responder
`default_nettype wire

// ===== verif/ppr_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module ppr_host_model (
   // clock and pacing
   input  wire logic           clk_i,
   input  wire logic           slow_i,
   // command frames toward the responder
   output var ppr_pkg::ppr_frame_s frame_o,
   output logic                frame_valid_o,
   // reply bytes from the responder
   input  wire logic           tx_valid_i,
   input  wire logic [7:0]     tx_data_i,
   output logic                tx_ready_o
);
   import ppr_pkg::*;

   logic [7:0] rx_q [$];

   initial begin
      frame_o       = '0;
      frame_valid_o = 1'b0;
   end

   // end-around-carry add, as the host forms its checksum
   function automatic logic [7:0] eac(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[7:0] + {7'h00, s[8]};
   endfunction

   // one frame held for a single cycle; bad spoils the checksum on purpose
   task automatic send(input logic [7:0] dev, input logic [7:0] cmd, input logic [7:0] p1,
                       input logic [7:0] p2, input logic bad);
      logic [7:0] sum;
      sum = eac(eac(eac(dev, cmd), p1), p2) ^ {7'h00, bad};
      @(posedge clk_i);
      frame_o       <= '{dev, cmd, p1, p2, sum};
      frame_valid_o <= 1'b1;
      @(posedge clk_i);
      frame_valid_o <= 1'b0;
      frame_o       <= ~frame_o;   // released lines must not keep the old frame
   endtask

   // sink: stalls at random when slow, so the reply buffer has to hold
   always @(posedge clk_i) begin
      if (tx_valid_i && tx_ready_o) begin
         rx_q.push_back(tx_data_i);
      end
      tx_ready_o <= slow_i ? ($urandom_range(3) == 0) : 1'b1;
   end
endmodule // ppr_host_model
`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   import ppr_pkg::*;

   localparam int DEPTH = 384;   // last served block lies past the image on purpose

   logic        clk_i;
   logic        resetn_i = 1'b0;
   logic        slow     = 1'b0;
   logic        ce       = 1'b1;
   logic        img_we   = 1'b0;
   logic [8:0]  img_addr = 9'h000;
   logic [7:0]  img_data = 8'h00;
   logic [95:0] t1d;
   ppr_cfg_s    cfg;
   ppr_frame_s  frame;
   logic        frame_valid, tx_valid, tx_ready, busy, poll_done, t1_done;
   logic [7:0]  tx_data;
   logic [7:0]  img [DEPTH];
   logic [7:0]  exp_q [$];
   logic [15:0] sz;
   int          nblk;
   int          err_total    = 0;
   int          total_checks = 0;

   ppr_responder #(.IMG_DEPTH(DEPTH), .AW(9)) dut_u (
      .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce),
      .frame_i(frame), .frame_valid_i(frame_valid), .cfg_i(cfg), .t1_desc_i(t1d),
      .img_we_i(img_we), .img_addr_i(img_addr), .img_data_i(img_data),
      .tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_ready_i(tx_ready),
      .busy_o(busy), .poll_done_o(poll_done), .t1_done_o(t1_done)
   );

   ppr_host_model host_u (
      .clk_i(clk_i), .slow_i(slow), .frame_o(frame), .frame_valid_o(frame_valid),
      .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready)
   );

   // 200 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   function automatic logic [7:0] rnd8();
      return 8'($urandom);
   endfunction

   // wrap the payload in exp_q: ack, result, data, data checksum
   function automatic void frame_up(input logic [7:0] res);
      logic [7:0] s;
      s = 8'h00;
      foreach (exp_q[i]) s = host_u.eac(s, exp_q[i]);
      exp_q.push_back(s);
      exp_q.push_front(res);
      exp_q.push_front(BYTE_ACK);
   endfunction

   // one command; waits for the reply to run dry, then compares with exp_q
   task automatic xact(input logic [7:0] dev, input logic [7:0] cmd, input logic [7:0] p1,
                       input logic [7:0] p2, input logic bad);
      int quiet;
      int n;
      host_u.rx_q.delete();
      host_u.send(dev, cmd, p1, p2, bad);
      quiet = 0;
      n = 0;
      while (quiet < 4 && n < 4000) begin
         @(negedge clk_i);
         quiet = (busy || tx_valid) ? 0 : quiet + 1;
         n++;
      end
      chk("reply done", {7'h00, quiet >= 4}, 8'h01);
      chk("reply length", 8'(host_u.rx_q.size()), 8'(exp_q.size()));
      foreach (exp_q[i]) begin
         if (i < host_u.rx_q.size()) chk("reply byte", host_u.rx_q[i], exp_q[i]);
      end
   endtask

   task automatic exp_poll();
      exp_q = {sz[7:0], sz[15:8], cfg.dev_addr, cfg.version};
      frame_up(BYTE_DONE);
   endtask

   // main poll at a random address; ans says whether this retry hits the slot
   task automatic poll(input bit ans);
      if (ans) exp_poll();
      else exp_q.delete();
      xact(rnd8(), CMD_POLL, POLL_MAIN, POLL_MAIN, 1'b0);
   endtask

   task automatic dl(input int b);
      exp_q = {BYTE_NAK};
      if (b < nblk) begin
         exp_q.delete();
         for (int k = 0; k < 128; k++) begin
            exp_q.push_back((b * 128 + k < DEPTH) ? img[b * 128 + k] : 8'h00);
         end
         frame_up(((b + 1) * 128 > DEPTH) ? BYTE_ERR : BYTE_DONE);
      end
      xact(cfg.dev_addr, CMD_DOWNLOAD, 8'(b), rnd8(), 1'b0);
   endtask

   // hang guard, well beyond the expected run length
   initial begin
      repeat (60000) @(posedge clk_i);
      err_total++;
      test_done();
   end

   initial begin
      void'($urandom(51703));
      // odd size on purpose: the report must round it up
      cfg = '{dev_addr: 8'h31 + 8'($urandom_range(12)), version: rnd8(), hsize: 16'h0181,
              slot: 5'h03, letter: 8'h48, unit: 8'h01};
      t1d = {$urandom, $urandom, $urandom};
      sz = cfg.hsize + {15'h0000, cfg.hsize[0]};
      nblk = (int'(sz) + 127) / 128;
      repeat (20) @(posedge clk_i);
      resetn_i <= 1'b1;
      for (int a = 0; a < DEPTH; a++) begin
         img[a] = rnd8();
         @(posedge clk_i);
         img_we   <= 1'b1;
         img_addr <= 9'(a);
         img_data <= img[a];
      end
      @(posedge clk_i);
      img_we <= 1'b0;
      @(negedge clk_i);
      chk("idle flags", {4'h0, busy, poll_done, t1_done, tx_valid}, 8'h00);

      // type-one poll: descriptor once, refusal afterwards; bad sum and odd command
      exp_q.delete();
      for (int i = 0; i < 12; i++) begin
         exp_q.push_back(t1d[8*i +: 8]);
      end
      frame_up(BYTE_DONE);
      xact(cfg.dev_addr, CMD_T1_POLL, rnd8(), rnd8(), 1'b0);
      chk("t1 flag", {7'h00, t1_done}, 8'h01);
      exp_q = {BYTE_NAK};
      xact(cfg.dev_addr, CMD_T1_POLL, 8'h00, 8'h00, 1'b0);
      exp_q.delete();
      xact(cfg.dev_addr, CMD_DOWNLOAD, 8'h00, 8'h00, 1'b1);
      exp_q = {BYTE_NAK};
      xact(cfg.dev_addr, 8'h52, 8'h00, 8'h00, 1'b0);
      $display("test type-one and framing done");

      // two retries, null poll restarts the count, then answer in the slot only
      poll(0);
      poll(0);
      exp_q.delete();
      xact(rnd8(), CMD_POLL, POLL_NULL, POLL_NULL, 1'b0);
      // a frozen block must not count this retry
      @(posedge clk_i);
      ce <= 1'b0;
      xact(rnd8(), CMD_POLL, POLL_MAIN, POLL_MAIN, 1'b0);
      @(posedge clk_i);
      ce <= 1'b1;
      for (int k = 1; k <= int'(cfg.slot); k++) begin
         poll(k == int'(cfg.slot));
      end
      chk("poll flag", {7'h00, poll_done}, 8'h01);
      poll(0);
      $display("test main poll done");

      // poll reset lifts the flag silently; a foreign command breaks the run
      exp_q.delete();
      xact(8'h4f, CMD_POLL, POLL_RESET, POLL_RESET, 1'b0);
      chk("poll flag", {7'h00, poll_done}, 8'h00);
      poll(0);
      poll(0);
      exp_q.delete();
      xact(cfg.dev_addr ^ 8'h80, CMD_DOWNLOAD, 8'h00, 8'h00, 1'b0);
      poll(0);
      poll(0);
      poll(1);
      $display("test poll reset done");

      // targeted poll: wrong unit stays silent, matching name answers
      exp_q.delete();
      xact(8'h4f, CMD_POLL, POLL_RESET, POLL_RESET, 1'b0);
      xact(8'h4f, CMD_POLL, cfg.letter, cfg.unit + 8'h01, 1'b0);
      exp_poll();
      xact(8'h4f, CMD_POLL, cfg.letter, cfg.unit, 1'b0);
      $display("test targeted poll done");

      // every block with a stalling receiver, then one block past the end
      slow <= 1'b1;
      for (int b = 0; b <= nblk; b++) begin
         dl(b);
      end
      $display("test download done");
      test_done();
   end
endmodule // tb
`default_nettype wire
